// file: design/epr_defs.svh
`ifndef EPR_DEFS_SVH
`define EPR_DEFS_SVH

// PCI clock numbers within one target transaction (clock 1 = address)
`define EPR_LAUNCH_CLK  4'h4
`define EPR_RETRY_CLK   4'h8
`define EPR_XFER_CLK    4'h5
`define EPR_FIRST_CNT   4'h2

// Port-side response counts in PCI clocks
`define EPR_HOLD_CLKS   2'h3
`define EPR_FILT_CLKS   2

// Captured byte buffer
`define EPR_DATA_W      8
`define EPR_FIFO_DEPTH  8

`endif

// file: design/epr_pkg.sv
package epr_pkg;

  typedef enum logic [1:0] {
    EPR_P_IDLE  = 2'b00,
    EPR_P_WAIT  = 2'b01,
    EPR_P_HOLD  = 2'b10,
    EPR_P_DONE  = 2'b11
  } epr_port_st_t;

  typedef enum logic [1:0] {
    EPR_T_NONE   = 2'b00,
    EPR_T_LAUNCH = 2'b01,
    EPR_T_RETRY  = 2'b10,
    EPR_T_XFER   = 2'b11
  } epr_txn_t;

endpackage

// file: design/epr_stream_if.sv
`timescale 1ns/1ps
interface epr_stream_if #(
  parameter int WIDTH = 8
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input  ready);
  modport snk (input  valid, input  data, output ready);
endinterface

// file: design/epr_fifo.sv
`timescale 1ns/1ps
module epr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_b_i,
  // Streams
  epr_stream_if.snk  wr,
  epr_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign wr.ready = (count != DEPTH[AW:0]);
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rd_ptr];

  always_comb begin
    push        = wr.valid & wr.ready;
    pop         = rd.valid & rd.ready;
    next_wr_ptr = push ? AW'((32'(wr_ptr) + 1) % DEPTH) : wr_ptr;
    next_rd_ptr = pop  ? AW'((32'(rd_ptr) + 1) % DEPTH) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage carries no reset; only pointers define contents
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end
endmodule // epr_fifo

// file: design/epr_read_cycle.sv
`timescale 1ns/1ps
`include "epr_defs.svh"
module epr_read_cycle (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  // PCI target side, decoded read of the data register
  input  wire logic                   pci_rd_start_i,
  output logic                        pci_trdy_o,
  output logic                        pci_stop_o,
  output logic [`EPR_DATA_W-1:0]      pci_rdata_o,
  // Configuration
  input  wire logic                   filter_en_i,
  // Parallel port pins
  input  wire logic                   busy_i,
  input  wire logic [`EPR_DATA_W-1:0] port_data_lines_i,
  output logic [`EPR_DATA_W-1:0]      port_data_lines_o,
  output logic                        port_data_lines_oe_o,
  output logic                        data_strobe_b_o,
  output logic                        port_busy_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and optional busy filter

  logic                   busy_meta;
  logic                   busy_sync;
  logic [`EPR_FILT_CLKS-1:0] busy_filt;
  logic [`EPR_DATA_W-1:0] pd_meta;
  logic [`EPR_DATA_W-1:0] pd_sync;
  logic [`EPR_FILT_CLKS-1:0] next_busy_filt;
  logic                   busy_seen;

  always_comb begin
    next_busy_filt = {busy_filt[`EPR_FILT_CLKS-2:0], busy_sync};
    // Filter costs extra latency on both busy edges
    busy_seen = filter_en_i ? busy_filt[`EPR_FILT_CLKS-1] : busy_sync;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_meta <= 1'b0;
      busy_sync <= 1'b0;
      busy_filt <= '0;
      pd_meta   <= '0;
      pd_sync   <= '0;
    end else begin
      busy_meta <= busy_i;
      busy_sync <= busy_meta;
      busy_filt <= next_busy_filt;
      pd_meta   <= port_data_lines_i;
      pd_sync   <= pd_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Captured byte buffer

  epr_stream_if #(.WIDTH(`EPR_DATA_W)) cap_s ();
  epr_stream_if #(.WIDTH(`EPR_DATA_W)) ret_s ();

  epr_fifo #(
    .WIDTH (`EPR_DATA_W),
    .DEPTH (`EPR_FIFO_DEPTH)
  ) u_fifo (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .wr      (cap_s),
    .rd      (ret_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // PCI transaction sequencer

  logic [3:0]        txn_clk;
  epr_pkg::epr_txn_t txn_kind;
  logic [3:0]        next_txn_clk;
  epr_pkg::epr_txn_t next_txn_kind;
  logic              next_trdy;
  logic              next_stop;
  logic [`EPR_DATA_W-1:0] next_rdata;
  logic              launch;
  epr_pkg::epr_port_st_t port_st;

  always_comb begin
    next_txn_clk  = txn_clk;
    next_txn_kind = txn_kind;
    next_trdy     = 1'b0;
    next_stop     = 1'b0;
    next_rdata    = pci_rdata_o;
    launch        = 1'b0;
    ret_s.ready   = 1'b0;
    if (txn_kind == epr_pkg::EPR_T_NONE) begin
      // Start seen in clock 1; counter then names the coming clock
      if (pci_rd_start_i) begin
        next_txn_clk = `EPR_FIRST_CNT;
        if (ret_s.valid) begin
          next_txn_kind = epr_pkg::EPR_T_XFER;
        end else if (port_st == epr_pkg::EPR_P_IDLE && cap_s.ready) begin
          next_txn_kind = epr_pkg::EPR_T_LAUNCH;
        end else begin
          // Byte not back yet: retry again, never a second port cycle
          next_txn_kind = epr_pkg::EPR_T_RETRY;
        end
      end
    end else begin
      next_txn_clk = txn_clk + 4'h1;
      if (txn_kind == epr_pkg::EPR_T_LAUNCH &&
          txn_clk == `EPR_LAUNCH_CLK - 4'h1) begin
        launch = 1'b1;
      end
      if (txn_kind == epr_pkg::EPR_T_XFER) begin
        if (txn_clk == `EPR_XFER_CLK - 4'h1) begin
          next_trdy     = 1'b1;
          next_rdata    = ret_s.data;
          ret_s.ready   = 1'b1;
          next_txn_kind = epr_pkg::EPR_T_NONE;
          next_txn_clk  = 4'h0;
        end
      end else if (txn_clk == `EPR_RETRY_CLK - 4'h1) begin
        // Port handshake runs on untouched after the retry
        next_stop     = 1'b1;
        next_txn_kind = epr_pkg::EPR_T_NONE;
        next_txn_clk  = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      txn_clk     <= 4'h0;
      txn_kind    <= epr_pkg::EPR_T_NONE;
      pci_trdy_o  <= 1'b0;
      pci_stop_o  <= 1'b0;
      pci_rdata_o <= '0;
    end else begin
      txn_clk     <= next_txn_clk;
      txn_kind    <= next_txn_kind;
      pci_trdy_o  <= next_trdy;
      pci_stop_o  <= next_stop;
      pci_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port-side handshake

  logic [1:0]            hold_cnt;
  logic [1:0]            next_hold_cnt;
  epr_pkg::epr_port_st_t next_port_st;
  logic                  next_strobe_b;
  logic                  next_port_busy;

  always_comb begin
    next_port_st   = port_st;
    next_hold_cnt  = hold_cnt;
    next_strobe_b  = data_strobe_b_o;
    next_port_busy = port_busy_o;
    cap_s.valid    = 1'b0;
    cap_s.data     = pd_sync;
    case (port_st)
      epr_pkg::EPR_P_IDLE: begin
        if (launch) begin
          next_strobe_b  = 1'b0;
          next_port_busy = 1'b1;
          next_port_st   = epr_pkg::EPR_P_WAIT;
        end
      end
      epr_pkg::EPR_P_WAIT: begin
        // Peripheral answers the low strobe with busy
        if (busy_seen) begin
          next_hold_cnt = `EPR_HOLD_CLKS - 2'h1;
          next_port_st  = epr_pkg::EPR_P_HOLD;
        end
      end
      epr_pkg::EPR_P_HOLD: begin
        if (hold_cnt == 2'h0) begin
          next_strobe_b = 1'b1;
          cap_s.valid   = 1'b1;
          next_port_st  = epr_pkg::EPR_P_DONE;
        end else begin
          next_hold_cnt = hold_cnt - 2'h1;
        end
      end
      epr_pkg::EPR_P_DONE: begin
        if (!busy_seen) begin
          next_port_busy = 1'b0;
          next_port_st   = epr_pkg::EPR_P_IDLE;
        end
      end
      default: begin
        next_port_st = epr_pkg::EPR_P_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      port_st              <= epr_pkg::EPR_P_IDLE;
      hold_cnt             <= 2'h0;
      data_strobe_b_o      <= 1'b1;
      port_busy_o          <= 1'b0;
      port_data_lines_o    <= '0;
      port_data_lines_oe_o <= 1'b0;
    end else begin
      port_st              <= next_port_st;
      hold_cnt             <= next_hold_cnt;
      data_strobe_b_o      <= next_strobe_b;
      port_busy_o          <= next_port_busy;
      // A read cycle never drives the data lines
      port_data_lines_o    <= '0;
      port_data_lines_oe_o <= 1'b0;
    end
  end

endmodule // epr_read_cycle

// file: verification/epr_read_cycle_asserts.sv
`timescale 1ns/1ps
module epr_read_cycle_asserts (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pci_rd_start_i,
  input wire logic pci_trdy_o,
  input wire logic pci_stop_o,
  input wire logic filter_en_i,
  input wire logic busy_i,
  input wire logic data_strobe_b_o,
  input wire logic port_busy_o,
  input wire logic port_data_lines_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////
  launch_clk_a: assert property ($fell(data_strobe_b_o) |->
    $past(pci_rd_start_i, 3) && port_busy_o) else $error("launch late");
  retry_clk_a: assert property ($fell(data_strobe_b_o) |->
    ##4 pci_stop_o) else $error("no retry in clock 8");
  stop_src_a: assert property (pci_stop_o |->
    $past(pci_rd_start_i, 7) ##1 !pci_stop_o) else $error("stray stop");
  xfer_clk_a: assert property (pci_trdy_o |->
    $past(pci_rd_start_i, 4) && !pci_stop_o) else $error("stray trdy");
  no_relaunch_a: assert property ($fell(data_strobe_b_o) |->
    !$past(port_busy_o) ##1 !pci_trdy_o) else $error("second launch");
  // Two sync flops, one decode edge, then the three-clock hold
  release_plain_a: assert property (
    $rose(data_strobe_b_o) && !filter_en_i |->
    $past(busy_i, 6) && !$past(busy_i, 7)) else $error("release timing");
  release_filt_a: assert property (
    $rose(data_strobe_b_o) && filter_en_i |->
    $past(busy_i, 8) && !$past(busy_i, 9)) else $error("filter timing");
  undriven_a: assert property (!port_data_lines_oe_o)
    else $error("data lines driven");
  cover property (pci_stop_o);
  cover property (pci_trdy_o);
  cover property ($rose(data_strobe_b_o) && filter_en_i);
endmodule // epr_read_cycle_asserts

bind epr_read_cycle epr_read_cycle_asserts epr_read_cycle_asserts_i (
  .clk_i, .rst_b_i, .pci_rd_start_i, .pci_trdy_o, .pci_stop_o,
  .filter_en_i, .busy_i, .data_strobe_b_o, .port_busy_o,
  .port_data_lines_oe_o);

// file: verification/epr_periph.sv
`timescale 1ns/1ps
module epr_periph (
  // Port side
  input  wire logic       clk_i,
  input  wire logic       data_strobe_b_i,
  input  wire logic [7:0] byte_i,
  input  wire logic [3:0] lag_i,
  output logic            busy_o,
  output logic [7:0]      data_o
);
  int cnt = 0;
  initial busy_o = 1'b0;
  initial data_o = 8'hFF;
  // Released lines show the inverse: no pull on the data lines
  always @(posedge clk_i) begin
    if (busy_o == data_strobe_b_i) begin
      cnt <= cnt + 1;
      if (cnt >= lag_i) begin
        cnt <= 0;
        busy_o <= #1 ~busy_o;
        data_o <= #1 busy_o ? ~byte_i : byte_i;
      end
    end else cnt <= 0;
  end
endmodule // epr_periph

// file: verification/epr_read_cycle_test.sv
`timescale 1ns/1ps
module epr_read_cycle_test;
  logic       clk_i = 0, rst_b_i = 0, start = 0, filt = 0;
  logic       busy, trdy, stop, oe, stb_b, pbusy;
  logic [7:0] rdata, pd_dut, pd_per, pd, d, byte_v = 8'h00;
  logic [3:0] lag = 4'h1;
  int         fail_count = 0, total_checks = 0, cyc = 0;
  int         st, tr, fl, low, l0, falls = 0;
  assign pd = oe ? pd_dut : pd_per;
  epr_read_cycle epr_read_cycle_i (.clk_i, .rst_b_i,
    .pci_rd_start_i(start), .pci_trdy_o(trdy), .pci_stop_o(stop),
    .pci_rdata_o(rdata), .filter_en_i(filt), .busy_i(busy),
    .port_data_lines_i(pd), .port_data_lines_o(pd_dut),
    .port_data_lines_oe_o(oe), .data_strobe_b_o(stb_b),
    .port_busy_o(pbusy));
  epr_periph epr_periph_i (.clk_i, .data_strobe_b_i(stb_b),
    .byte_i(byte_v), .lag_i(lag), .busy_o(busy), .data_o(pd_per));
  initial forever #2.5 clk_i = ~clk_i;
  always @(negedge stb_b) falls++;
  always @(posedge clk_i) if (++cyc == 4000) begin
    fail_count++;
    results();
  end
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // Sample n holds the value of PCI clock n
  task automatic pci_read();
    int f0;
    st = 0; tr = 0; fl = 0;
    @(posedge clk_i); #1 start = 1;
    f0 = falls;
    @(posedge clk_i); #1 start = 0;
    for (int n = 2; n <= 9; n++) begin
      if (stop === 1'b1) st = n;
      if (trdy === 1'b1) begin tr = n; d = rdata; end
      if (falls != f0 && fl == 0) fl = n;
      @(posedge clk_i); #1;
    end
  endtask
  task automatic wait_idle();
    low = 0;
    for (int n = 0; n < 200 && pbusy !== 1'b0; n++) begin
      if (stb_b === 1'b0) low++;
      @(posedge clk_i); #1;
    end
    check(pbusy, 0);
  endtask
  task automatic fresh_retry(input logic f, input logic [7:0] b);
    filt = f;
    byte_v = b;
    pci_read();
    check(st, 8);
    check(tr, 0);
    check(fl, 4);
    wait_idle();
    pci_read();
    check(tr, 5);
    check(fl, 0);
    check(d, b);
  endtask
  ////////////////////////////////////////
  task automatic test_filter();
    fresh_retry(0, 8'hA5);
    l0 = low;
    fresh_retry(1, 8'h5A);
    check(low, l0 + 2);
    filt = 0;
  endtask
  // Slow peripheral keeps the port busy across a second read
  task automatic test_refuse();
    lag = 4'hA;
    byte_v = 8'h3C;
    pci_read();
    check(st, 8);
    check(fl, 4);
    pci_read();
    check(st, 8);
    check(fl, 0);
    check(tr, 0);
    wait_idle();
    lag = 4'h1;
    pci_read();
    check(tr, 5);
    check(d, 8'h3C);
  endtask
  task automatic test_reset();
    byte_v = 8'hC3;
    pci_read();
    rst_b_i = 0;
    @(posedge clk_i); #1;
    check(stb_b, 1);
    check(pbusy, 0);
    check(oe, 0);
    check(pd_dut, 8'h00);
    rst_b_i = 1;
    // Let the peripheral drop busy before the next launch
    repeat (8) @(posedge clk_i);
    #1 fresh_retry(0, 8'h96);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    #1 rst_b_i = 1;
    test_filter();
    test_refuse();
    test_reset();
    results();
  end
endmodule // epr_read_cycle_test
